// [hdl/rtc_trim_alarm.sv]
// Notes on behaviour
// - Two-day trim keeps bits 4..0 only; upper three bits read zero.
// - Two-day correction alternates day-one and day-two amounts endlessly.
// - Code v two's complement; day one trunc(v/2), day two v minus that.
// - Daily correction applied once at 00:00:30, away from zero-second alarms.
// - Negative correction discards that many one-hertz ticks; time stands still.
// - Eight-second trim spreads its correction over eight seconds, sigma-delta style.
// - All eight bits of eight-second trim are a two's-complement step count.
// - Positive code shortens the second, negative code lengthens it.
// - Alarm one lives at 07h..0Ah, alarm two at 0Bh..0Dh.
// - Bit seven of each alarm register masks its field from comparison.
// - Day/date bit six picks weekday (1) or day of month (0).
// - An alarm match sets that alarm's flag.
// - Flag drives an interrupt output only while its enable is one.
// - Alarms are compared only on the once-per-second time update.
// - Alarm one masks select every second down to full date match.
// - Alarm two fires at zero seconds; masks add minutes, hours, day.
// - Interrupt control picks combined or secondary pin as the one shared alarm output.
// - Interrupt control one puts alarms on combined pin, zero puts square wave.
// - Alarm flags clear only by writing zero; writing one leaves them.
`timescale 1ns/1ps
`include "rtc_trim_alarm_map.svh"

module rtc_trim_alarm (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_32k,
  input wire logic reg_wr,
  input wire rtc_trim_alarm_pkg::reg_addr_t reg_addr,
  input wire rtc_trim_alarm_pkg::byte_t reg_wdata,
  output rtc_trim_alarm_pkg::byte_t reg_rdata,
  input wire logic time_update,
  input wire rtc_trim_alarm_pkg::byte_t time_seconds,
  input wire rtc_trim_alarm_pkg::byte_t time_minutes,
  input wire rtc_trim_alarm_pkg::byte_t time_hours,
  input wire rtc_trim_alarm_pkg::byte_t time_weekday,
  input wire rtc_trim_alarm_pkg::byte_t time_monthday,
  output logic sec_tick,
  output logic combined_wave_irq_pin_n,
  output logic secondary_irq_pin_n
);
  import rtc_trim_alarm_pkg::*;

  rtc_state_t st_reg;
  rtc_state_t st_next;

  // Working values of the next-state process
  logic osc_edge;
  logic base_tick;
  logic signed [11:0] trim_ext;
  logic signed [11:0] k_now;
  logic signed [11:0] k_after;
  logic signed [11:0] part_now;
  logic signed [11:0] part_after;
  logic signed [11:0] step_delta;
  logic [15:0] limit;
  logic signed [5:0] day_code;
  // Sum kept signed so the halving shift keeps the sign
  logic signed [5:0] day_sum;
  logic signed [5:0] day_half;
  logic signed [5:0] day_amt;
  logic [5:0] day_mag;
  logic at_adjust;
  logic a1_hit;
  logic a2_hit;
  logic [7:0] a1_day_ref;
  logic [7:0] a2_day_ref;
  logic wr_status;
  logic [2:0] alarm_idx;
  logic sq_src;
  logic a1_irq;
  logic a2_irq;

  always_comb begin
    st_next = st_reg;
    alarm_idx = 3'(reg_addr - `ADDR_ALARM_FIRST);

    // Crystal input: three-stage synchroniser, stage one read only by stage two
    // The crystal is not related to clk; a level counts only once stages two
    // and three agree, so a metastable sample never makes a double edge.
    st_next.osc_sync = {st_reg.osc_sync[1:0], osc_32k};
    osc_edge = 1'b0;
    if (st_reg.osc_sync[1] == st_reg.osc_sync[2] && st_reg.osc_sync[2] != st_reg.osc_level) begin
      st_next.osc_level = st_reg.osc_sync[2];
      osc_edge = st_reg.osc_sync[2];
    end

    // Rate trim works on whole crystal cycles, so no fractional phase is kept;
    // the error left after eight seconds is zero because the shares add up.
    // Twelve bits are enough: eight times the largest code still fits.
    // signed step count
    trim_ext = {{4{st_reg.rate_trim[7]}}, st_reg.rate_trim};
    // spread over eight seconds
    // Each step is one crystal cycle per eight seconds; the share of second i is
    // floor(t*(i+1)/8) - floor(t*i/8), so the eight shares always sum to t exactly.
    k_now = $signed({9'd0, st_reg.eighth});
    k_after = k_now + 12'sd1;
    part_now = 12'(trim_ext * k_now);
    part_after = 12'(trim_ext * k_after);
    step_delta = (part_after >>> 3) - (part_now >>> 3);
    limit = `PRESCALE_NOMINAL - {{4{step_delta[11]}}, step_delta};

    // Prescaler of crystal edges into the trimmed second
    // The limit follows the current eighth on every edge; a trim written
    // mid-second already acts on the second that is running.
    base_tick = 1'b0;
    if (osc_edge) begin
      if (st_reg.div_cnt >= limit - 16'h0001) begin
        st_next.div_cnt = 16'h0000;
        st_next.eighth = st_reg.eighth + 3'h1;
        base_tick = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 16'h0001;
      end
    end

    // Tick issue: skipped ticks are swallowed, extra ticks fill idle cycles
    // An extra tick never shares a cycle with a base tick, so the calendar
    // sees one pulse per cycle and carries each one normally.
    // Limitation: extra ticks come in back-to-back clk cycles, not seconds.
    st_next.sec_tick = 1'b0;
    if (base_tick) begin
      if (st_reg.skip_cnt != 4'h0) begin
        st_next.skip_cnt = st_reg.skip_cnt - 4'h1;
      end else begin
        st_next.sec_tick = 1'b1;
      end
    end else if (st_reg.extra_cnt != 4'h0) begin
      st_next.sec_tick = 1'b1;
      st_next.extra_cnt = st_reg.extra_cnt - 4'h1;
    end

    // trunc(v/2) then remainder
    // Adding one before the shift for negative codes turns the floor of the
    // arithmetic shift into a truncation toward zero.
    day_code = {st_reg.day_trim[4], st_reg.day_trim};
    day_sum = day_code + $signed({5'd0, st_reg.day_trim[4]});
    day_half = day_sum >>> 1;
    // Magnitude is at most eight, so four bits of count suffice
    day_amt = st_reg.day_two ? day_code - day_half : day_half;
    day_mag = day_amt[5] ? 6'(-day_amt) : day_amt;

    // once at 00:00:30
    // Both 24-hour and 12-hour midnight codes are accepted.
    // Pending ticks drain long before the next instant a day later.
    // Extra ticks move the seconds past 30 and skipped ticks bring no update,
    // so the instant is seen only once per day.
    at_adjust = time_update && time_seconds[6:0] == `ADJ_SECONDS && time_minutes[6:0] == 7'h00
      && (time_hours[6:0] == `MIDNIGHT_24H || time_hours[6:0] == `MIDNIGHT_12H);
    if (at_adjust) begin
      if (day_amt[5]) begin
        st_next.skip_cnt = day_mag[3:0];
      end else begin
        st_next.extra_cnt = day_mag[3:0];
      end
      st_next.day_two = ~st_reg.day_two;
    end

    // Only the low six bits of the day field take part; bit six is the selector
    // weekday or day of month
    a1_day_ref = st_reg.alarm[3][`ALARM_DAYSEL_BIT] ? time_weekday : time_monthday;
    a2_day_ref = st_reg.alarm[6][`ALARM_DAYSEL_BIT] ? time_weekday : time_monthday;

    a1_hit = (st_reg.alarm[0][`ALARM_MASK_BIT] || st_reg.alarm[0][6:0] == time_seconds[6:0])
      && (st_reg.alarm[1][`ALARM_MASK_BIT] || st_reg.alarm[1][6:0] == time_minutes[6:0])
      && (st_reg.alarm[2][`ALARM_MASK_BIT] || st_reg.alarm[2][6:0] == time_hours[6:0])
      && (st_reg.alarm[3][`ALARM_MASK_BIT] || st_reg.alarm[3][5:0] == a1_day_ref[5:0]);
    // Alarm two has no seconds register, so zero seconds is a fixed term
    // alarm two at zero seconds
    a2_hit = time_seconds[6:0] == 7'h00
      && (st_reg.alarm[4][`ALARM_MASK_BIT] || st_reg.alarm[4][6:0] == time_minutes[6:0])
      && (st_reg.alarm[5][`ALARM_MASK_BIT] || st_reg.alarm[5][6:0] == time_hours[6:0])
      && (st_reg.alarm[6][`ALARM_MASK_BIT] || st_reg.alarm[6][5:0] == a2_day_ref[5:0]);

    // Register writes
    // Unmapped offsets fall through every branch and leave the state alone.
    // Writes and reads may come back to back; a read sees a write one cycle on.
    wr_status = reg_wr && reg_addr == `ADDR_STATUS;
    if (reg_wr) begin
      if (reg_addr >= `ADDR_ALARM_FIRST && reg_addr <= `ADDR_ALARM_LAST) begin
        st_next.alarm[alarm_idx] = reg_wdata;
      end
      if (reg_addr == `ADDR_CONTROL) begin
        st_next.ctrl = reg_wdata & `CTRL_RESERVED_MASK;
      end
      if (reg_addr == `ADDR_TWO_DAY_SECONDS_TRIM) begin
        st_next.day_trim = reg_wdata[4:0];
      end
      if (reg_addr == `ADDR_EIGHT_SECOND_RATE_TRIM) begin
        st_next.rate_trim = reg_wdata;
      end
    end

    // Each flag bit clears on its own; a one in the other bit keeps that flag
    // flags clear only on zero
    if (wr_status && !reg_wdata[`STAT_ALARM_ONE_FLAG_BIT]) begin
      st_next.a1_flag = 1'b0;
    end
    if (wr_status && !reg_wdata[`STAT_ALARM_TWO_FLAG_BIT]) begin
      st_next.a2_flag = 1'b0;
    end
    // match sets flag
    // A match in the same cycle as a clearing write wins, so no event is lost.
    if (time_update && a1_hit) begin
      st_next.a1_flag = 1'b1;
    end
    if (time_update && a2_hit) begin
      st_next.a2_flag = 1'b1;
    end

    // Square wave source picked by the rate bits
    // The divided rates are only as even as the crystal edges; the trimmed
    // second stretches or shrinks the low half of the 1 Hz wave.
    case ({st_reg.ctrl[`CTRL_RATE_HI_BIT], st_reg.ctrl[`CTRL_RATE_LO_BIT]})
      2'b00: sq_src = st_reg.div_cnt < `PRESCALE_HALF;
      2'b01: sq_src = st_reg.div_cnt[2];
      2'b10: sq_src = st_reg.div_cnt[1];
      2'b11: sq_src = st_reg.osc_level;
      default: sq_src = 1'b0;
    endcase
    st_next.wave = sq_src;

    // Next flag value is used so the pin falls in the cycle after the match
    // enable gates each flag
    a1_irq = st_next.a1_flag && st_reg.ctrl[`CTRL_ALARM_ONE_IRQ_ENABLE_BIT];
    a2_irq = st_next.a2_flag && st_reg.ctrl[`CTRL_ALARM_TWO_IRQ_ENABLE_BIT];
    // Interrupt pins are active low and idle high
    // one shared alarm output, combined or secondary pin
    if (st_reg.ctrl[`CTRL_INTCTL_BIT]) begin
      st_next.combined_n = ~(a1_irq || a2_irq);
      st_next.secondary_n = 1'b1;
    end else begin
      st_next.combined_n = sq_src;
      st_next.secondary_n = ~(a1_irq || a2_irq);
    end

    // Read data, one cycle behind the address; unmapped offsets read zero
    // Registered read data keeps the bus output free of address glitches
    st_next.rdata = 8'h00;
    if (reg_addr >= `ADDR_ALARM_FIRST && reg_addr <= `ADDR_ALARM_LAST) begin
      st_next.rdata = st_reg.alarm[alarm_idx];
    end else begin
      case (reg_addr)
        `ADDR_CONTROL: st_next.rdata = st_reg.ctrl;
        `ADDR_STATUS: st_next.rdata = {6'd0, st_reg.a2_flag, st_reg.a1_flag};
        `ADDR_TWO_DAY_SECONDS_TRIM: st_next.rdata = {3'd0, st_reg.day_trim};
        `ADDR_EIGHT_SECOND_RATE_TRIM: st_next.rdata = st_reg.rate_trim;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset loads constants only
  // Reset is synchronous, so the crystal synchroniser is cleared with the rest
  // and a crystal already high after reset gives one edge, which is harmless.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg.osc_sync <= 3'h0;
      st_reg.osc_level <= 1'b0;
      st_reg.div_cnt <= 16'h0000;
      st_reg.eighth <= 3'h0;
      st_reg.day_trim <= `TWO_DAY_TRIM_RESET;
      st_reg.rate_trim <= `RATE_TRIM_RESET;
      st_reg.alarm <= {7{`ALARM_RESET}};
      st_reg.ctrl <= `CONTROL_RESET;
      st_reg.a1_flag <= 1'b0;
      st_reg.a2_flag <= 1'b0;
      st_reg.day_two <= 1'b0;
      st_reg.skip_cnt <= 4'h0;
      st_reg.extra_cnt <= 4'h0;
      st_reg.sec_tick <= 1'b0;
      st_reg.wave <= 1'b0;
      st_reg.combined_n <= 1'b1;
      st_reg.secondary_n <= 1'b1;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  // Every output is a flip-flop, so no pin sees a combinational hazard
  assign reg_rdata = st_reg.rdata;
  assign sec_tick = st_reg.sec_tick;
  assign combined_wave_irq_pin_n = st_reg.combined_n;
  assign secondary_irq_pin_n = st_reg.secondary_n;

endmodule : rtc_trim_alarm

// [pkg/rtc_trim_alarm_map.svh]
`ifndef RTC_TRIM_ALARM_MAP_SVH
`define RTC_TRIM_ALARM_MAP_SVH

// Register offsets on the internal register port
`define ADDR_ALARM_FIRST 5'h07
`define ADDR_ALARM_ONE_LAST 5'h0A
`define ADDR_ALARM_LAST 5'h0D
`define ADDR_CONTROL 5'h0E
`define ADDR_STATUS 5'h0F
`define ADDR_TWO_DAY_SECONDS_TRIM 5'h10
`define ADDR_EIGHT_SECOND_RATE_TRIM 5'h12

// Alarm register fields
`define ALARM_MASK_BIT 7
`define ALARM_DAYSEL_BIT 6

// Control register fields
`define CTRL_RATE_HI_BIT 4
`define CTRL_RATE_LO_BIT 3
`define CTRL_INTCTL_BIT 2
`define CTRL_ALARM_TWO_IRQ_ENABLE_BIT 1
`define CTRL_ALARM_ONE_IRQ_ENABLE_BIT 0
`define CTRL_RESERVED_MASK 8'hBF

// Status register fields
`define STAT_ALARM_TWO_FLAG_BIT 1
`define STAT_ALARM_ONE_FLAG_BIT 0

// Reset values
`define CONTROL_RESET 8'h38
`define ALARM_RESET 8'h00
`define TWO_DAY_TRIM_RESET 5'h00
`define RATE_TRIM_RESET 8'h00

// Time base: crystal edges per nominal second, half of it for the 1 Hz wave
`define PRESCALE_NOMINAL 16'h8000
`define PRESCALE_HALF 16'h4000

// Daily adjustment instant, BCD
`define ADJ_SECONDS 7'h30
`define MIDNIGHT_24H 7'h00
`define MIDNIGHT_12H 7'h52

`endif

// [pkg/rtc_trim_alarm_pkg.sv]
package rtc_trim_alarm_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [4:0] reg_addr_t;

  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_level;
    logic [15:0] div_cnt;
    logic [2:0] eighth;
    logic [4:0] day_trim;
    logic [7:0] rate_trim;
    logic [6:0][7:0] alarm;
    logic [7:0] ctrl;
    logic a1_flag;
    logic a2_flag;
    logic day_two;
    logic [3:0] skip_cnt;
    logic [3:0] extra_cnt;
    logic sec_tick;
    logic wave;
    logic combined_n;
    logic secondary_n;
    logic [7:0] rdata;
  } rtc_state_t;

endpackage : rtc_trim_alarm_pkg

// [tb/rtc_trim_alarm_properties.sv]
`timescale 1ns/1ps
module rtc_trim_alarm_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire rtc_trim_alarm_pkg::reg_addr_t reg_addr,
  input wire rtc_trim_alarm_pkg::byte_t reg_wdata,
  input wire rtc_trim_alarm_pkg::byte_t reg_rdata,
  input wire logic time_update,
  input wire logic secondary_irq_pin_n
);
  import rtc_trim_alarm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Readback paths, one cycle behind the address
  a_trim_low_back: assert property (reg_wr && reg_addr == 5'h10 ##1 !reg_wr && reg_addr == 5'h10
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F)) else $error("two-day trim readback wrong");
  a_rate_trim_back: assert property (reg_wr && reg_addr == 5'h12 ##1 !reg_wr && reg_addr == 5'h12
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("rate trim readback wrong");
  a_alarm_reg_back: assert property (reg_wr && reg_addr inside {[5'h07:5'h0D]} ##1
    !reg_wr && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("alarm readback wrong");
  a_unmapped_zero: assert property (reg_addr == 5'h11 || reg_addr > 5'h12
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_status_upper_zero: assert property (reg_addr == 5'h0F |=> reg_rdata[7:2] == 6'h00)
    else $error("status upper bits set");
  a_flag_clear_zero: assert property (reg_wr && reg_addr == 5'h0F && reg_wdata[1:0] == 2'b00 && !time_update
    ##1 !reg_wr && !time_update && reg_addr == 5'h0F |=> reg_rdata[1:0] == 2'b00) else $error("flag not cleared");
  // Interrupt pin moves only after an update or a write
  a_pin_fall_cause: assert property ($fell(secondary_irq_pin_n)
    |-> $past(time_update) || $past(time_update, 2) || $past(reg_wr) || $past(reg_wr, 2)) else $error("pin fell alone");
  a_pin_rise_cause: assert property ($rose(secondary_irq_pin_n) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("pin released alone");
endmodule : rtc_trim_alarm_properties

bind rtc_trim_alarm rtc_trim_alarm_properties i_props (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .time_update(time_update),
  .secondary_irq_pin_n(secondary_irq_pin_n));

// [tb/rtc_host_model.sv]
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic clk,
  output rtc_trim_alarm_pkg::reg_addr_t reg_addr,
  output rtc_trim_alarm_pkg::byte_t reg_wdata,
  output logic reg_wr,
  input wire rtc_trim_alarm_pkg::byte_t reg_rdata
);
  import rtc_trim_alarm_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  // host loads trims, listed masks only
  task automatic wr(input reg_addr_t a, input byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Stale data is not left on the bus
  endtask : wr
  // Read data settles one edge after the address
  task automatic rd(input reg_addr_t a, output byte_t v);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask : rd
endmodule : rtc_host_model

// [tb/test_rtc_trim_alarm_match.sv]
`timescale 1ns/1ps
module test_rtc_trim_and_alarm_match;
  import rtc_trim_alarm_pkg::*;
  logic clk;
  logic rst;
  logic osc_32k;
  logic reg_wr;
  reg_addr_t reg_addr;
  byte_t reg_wdata;
  byte_t reg_rdata;
  logic time_update;
  byte_t t_sec;
  byte_t t_min;
  byte_t t_hr;
  byte_t t_wd;
  byte_t t_md;
  logic sec_tick;
  logic combined_n;
  logic secondary_n;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int ticks = 0;
  int mdl[int];
  logic [15:0] seed = 16'h70D7;
  rtc_trim_alarm i_rtc_trim_alarm (.clk(clk), .rst(rst), .osc_32k(osc_32k), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .time_update(time_update),
    .time_seconds(t_sec), .time_minutes(t_min), .time_hours(t_hr), .time_weekday(t_wd),
    .time_monthday(t_md), .sec_tick(sec_tick), .combined_wave_irq_pin_n(combined_n),
    .secondary_irq_pin_n(secondary_n));
  rtc_host_model i_rtc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cycle ceiling against hangs; ticks counted as they come
  always @(posedge clk) begin
    cycles++;
    if (sec_tick === 1'b1) ticks++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input int exp, input logic [7:0] got);
    check_count++;
    if (got !== exp[7:0]) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp[7:0], got);
    end
  endtask : chk
  // Model keeps the register image with its write masks
  task automatic wrm(input int a, input int d);
    i_rtc_host_model.wr(a[4:0], d[7:0]);
    if (a == 16) mdl[a] = d & 'h1F;
    else if (a == 14) mdl[a] = d & 'hBF;
    else if (a == 15) mdl[a] = mdl[a] & d;
    else mdl[a] = d & 'hFF;
  endtask : wrm
  task automatic rdm(input int a);
    byte_t v;
    i_rtc_host_model.rd(a[4:0], v);
    chk("register", mdl.exists(a) ? mdl[a] : 0, v);
  endtask : rdm
  task automatic upd(input byte_t s, m, h, wd, md, input int fl);
    @(posedge clk);
    time_update <= 1'b1;
    {t_sec, t_min, t_hr, t_wd, t_md} <= {s, m, h, wd, md};
    @(posedge clk);
    time_update <= 1'b0;
    mdl[15] = mdl[15] | fl;
  endtask : upd
  task automatic pins(input int ea, input int eb);
    @(posedge clk);
    #1;
    if (ea >= 0) chk("combined pin", ea, {7'h00, combined_n});
    chk("secondary pin", eb, {7'h00, secondary_n});
  endtask : pins
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    int d1;
    {rst, osc_32k, time_update, t_sec, t_min, t_hr, t_wd, t_md} = '0;
    rst = 1'b1;
    mdl[14] = 'h38;
    mdl[15] = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 7; a < 20; a++) rdm(a);
    seed = lfsr(seed);
    wrm(16, seed[7:0] | 8'hE0); rdm(16);
    seed = lfsr(seed);
    wrm(18, seed); rdm(18); wrm(18, 'h80); rdm(18);
    for (int a = 7; a < 11; a++) wrm(a, 'h80);
    wrm(14, 'h05); repeat (5) @(posedge clk); rdm(15);
    upd(8'h13, 8'h22, 8'h05, 8'h02, 8'h11, 1); pins(0, 1); rdm(15);
    wrm(15, 'h03); rdm(15); wrm(15, 'h00); pins(1, 1); rdm(15);
    wrm(7, 'h25); upd(8'h24, 8'h22, 8'h05, 8'h02, 8'h11, 0); rdm(15);
    upd(8'h25, 8'h22, 8'h05, 8'h02, 8'h11, 1); pins(0, 1); rdm(15); wrm(15, 0);
    wrm(7, 'h10); wrm(8, 'h20); wrm(9, 'h08);
    for (int k = 0; k < 2; k++) begin
      wrm(10, k ? 'h05 : 'h45);
      upd(8'h10, 8'h20, 8'h08, k ? 8'h05 : 8'h03, k ? 8'h03 : 8'h05, 0); rdm(15);
      upd(8'h10, 8'h20, 8'h08, k ? 8'h03 : 8'h05, k ? 8'h05 : 8'h03, 1); rdm(15); wrm(15, 0);
    end
    for (int a = 11; a < 14; a++) wrm(a, 'h80);
    wrm(14, 'h02); upd(8'h01, 8'h20, 8'h08, 8'h02, 8'h11, 0); rdm(15);
    upd(8'h00, 8'h21, 8'h08, 8'h02, 8'h11, 2); pins(1, 0); rdm(15); wrm(15, 0);
    d1 = 15 / 2;
    wrm(16, 'h0F);
    ticks = 0; upd(8'h30, 8'h00, 8'h00, 8'h02, 8'h11, 0); repeat (20) @(posedge clk);
    chk("ticks day one", d1, ticks[7:0]);
    ticks = 0; upd(8'h31, 8'h00, 8'h00, 8'h02, 8'h11, 0); repeat (20) @(posedge clk);
    chk("ticks off instant", 0, ticks[7:0]);
    ticks = 0; upd(8'h30, 8'h00, 8'h52, 8'h03, 8'h12, 0); repeat (20) @(posedge clk);
    chk("ticks day two", 15 - d1, ticks[7:0]);
    wrm(16, 'h1B); rdm(16);
    ticks = 0; upd(8'h30, 8'h00, 8'h00, 8'h04, 8'h13, 0); repeat (20) @(posedge clk);
    chk("ticks negative day", 0, ticks[7:0]);
    // Square wave at crystal rate on the combined pin
    wrm(14, 'h18); osc_32k <= 1'b1; rdm(14); repeat (8) @(posedge clk);
    pins(1, 1);
    @(posedge clk); osc_32k <= 1'b0; repeat (8) @(posedge clk);
    pins(0, 1);
    stop_test();
  end
endmodule : test_rtc_trim_and_alarm_match
